/* File: design/fsr_defs.svh */
// constants for the flash status, interrupt and read-timing register set
// assumes a 32-bit register port with word-aligned byte offsets
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

// register byte offsets
`define FSR_OFS_WAIT_MODE 8'h00
`define FSR_OFS_STATUS 8'h04
`define FSR_OFS_IRQ_EN 8'h08
`define FSR_OFS_IRQ_FLAGS 8'h0c
`define FSR_OFS_IRQ_CLR 8'h10
`define FSR_OFS_TRIM 8'h14
`define FSR_OFS_WAIT_CNT 8'h18

// operation status field positions
`define FSR_ST_READY 0
`define FSR_ST_STALL 1
`define FSR_ST_ARRAY_ERASE 2
`define FSR_ST_SUSPEND 3
`define FSR_ST_SECTOR_ERASE 4
`define FSR_ST_PROGRAM 5

// interrupt enable, flag and clear field positions
`define FSR_IRQ_DONE 0
`define FSR_IRQ_STALL 1

// trim mirror field positions
`define FSR_TRIM_FREQ_LSB 0
`define FSR_TRIM_FREQ_MSB 9
`define FSR_TRIM_TEMP_LSB 16
`define FSR_TRIM_TEMP_MSB 20

// reset values
`define FSR_RST_WAIT_MODE 2'h1
`define FSR_RST_WAIT_CNT 4'h1
`define FSR_RST_IRQ_EN 2'h0

// read-wait mode encodings
`define FSR_MODE_ZERO 2'h0
`define FSR_MODE_ZERO_ONE 2'h1
`define FSR_MODE_BAD 2'h2
`define FSR_MODE_FIXED 2'h3

// flash words holding the trimming data
`define FSR_FL_FREQ_ADDR 32'h0010_0004
`define FSR_FL_TEMP_ADDR 32'h0010_0006

`endif

/* File: design/fsr_pkg.sv */
// types shared by the flash status register set
// no assumptions beyond a SystemVerilog compiler
package fsr_pkg;

  typedef enum logic [2:0] {
    FSR_LD_START = 3'b000,
    FSR_LD_FREQ = 3'b001,
    FSR_LD_TEMP = 3'b010,
    FSR_LD_DONE = 3'b011
  } fsr_ld_state_e;

endpackage

/* File: design/fsr_edge_flag.sv */
// sticky flag set on a rising edge of a level, cleared by a one-cycle pulse
// the level is synchronous to clk_in
`timescale 1ns/100ps
module fsr_edge_flag #(
  parameter logic PREV_INIT = 1'b0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // event and clear
  input wire logic level_in,
  input wire logic clear_in,
  // flag
  output logic flag_out
);

  logic prev;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      prev <= PREV_INIT;
    else if (ce_in)
      prev <= level_in;
  end

  // a rising edge in the clear cycle still sets the flag
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      flag_out <= 1'b0;
    else if (ce_in)
    begin
      if (level_in && !prev)
        flag_out <= 1'b1; // RULE8 RULE9 RULE23
      else if (clear_in)
        flag_out <= 1'b0;
    end
  end

endmodule

/* File: design/fsr_trim_loader.sv */
// fetches the two trimming words from flash once after reset release, unless fl_blank_in marks the flash blank
// flash read port answers on the same clock; blank flag is a same-clock level
`timescale 1ns/100ps
`include "fsr_defs.svh"
module fsr_trim_loader
  import fsr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // flash read port
  output logic fl_rd_req_out,
  output logic [31:0] fl_rd_addr_out,
  input wire logic [15:0] fl_rd_data_in,
  input wire logic fl_rd_valid_in,
  input wire logic fl_blank_in,
  // mirrored values
  output logic [9:0] freq_trim_out,
  output logic [4:0] temp_trim_out,
  output logic done_out
);

  fsr_ld_state_e state;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      state <= FSR_LD_START;
    else if (ce_in)
    begin
      case (state)
        FSR_LD_START:
          state <= fl_blank_in ? FSR_LD_DONE : FSR_LD_FREQ; // RULE17
        FSR_LD_FREQ:
          if (fl_rd_valid_in)
            state <= FSR_LD_TEMP;
        FSR_LD_TEMP:
          if (fl_rd_valid_in)
            state <= FSR_LD_DONE;
        default:
          state <= FSR_LD_DONE;
      endcase
    end
  end

  // erased flash leaves the mirror at its cleared reset value
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      freq_trim_out <= 10'h000;
      temp_trim_out <= 5'h00;
    end
    else if (ce_in && fl_rd_valid_in)
    begin
      if (state == FSR_LD_FREQ)
        freq_trim_out <= fl_rd_data_in[9:0]; // RULE15
      else if (state == FSR_LD_TEMP)
        temp_trim_out <= fl_rd_data_in[4:0]; // RULE14
    end
  end

  assign fl_rd_req_out = (state == FSR_LD_FREQ) || (state == FSR_LD_TEMP);
  assign fl_rd_addr_out = (state == FSR_LD_TEMP) ? `FSR_FL_TEMP_ADDR : `FSR_FL_FREQ_ADDR;
  assign done_out = (state == FSR_LD_DONE);

endmodule

/* File: design/fsr_regs.sv */
// flash status, interrupt, trim mirror and read-wait register set
// sequencer status inputs and flash read port are synchronous to clk_in;
// registers are reached through a plain strobe port with one-cycle read data
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "fsr_defs.svh"

// Notes on behaviour
// RULE1 - array erase status reads 1 during a full-array erase, else 0.
// RULE2 - stall status bit 1 reads 1 once an operation overran its timing.
// RULE3 - software issues the flash reset command when stall status reads 1.
// RULE4 - ready reads 0 while program or erase runs, commands refused; 1 after.
// RULE5 - interrupt raised while stall flag and stall enable are both 1.
// RULE6 - interrupt raised while done flag and done enable are both 1.
// RULE7 - software clears a flag before setting its enable.
// RULE8 - stall flag set on each rising stall edge, sticky, resets to 0.
// RULE9 - done flag set on each rising ready edge, sticky, resets to 0.
// RULE10 - writing 1 to clear bit 1 clears the stall flag.
// RULE11 - writing 1 to clear bit 0 clears the done flag.
// RULE12 - writing 0 to clear bits changes nothing; clear bits read 0.
// RULE13 - reserved bits ignore writes and read back an unspecified value.
// RULE14 - after reset, flash word bits 4:0 load trim mirror bits 20:16.
// RULE15 - after reset, flash word bits 9:0 load trim mirror bits 9:0.
// RULE16 - trim mirror readable in user and serial programming boot modes.
// RULE17 - trim mirror cleared by internal reset after flash data erase.
// RULE18 - software saves trim values before erasing flash.
// RULE19 - wait count field takes odd codes 1 to 15, resets to 0001.
// RULE20 - wait count applied only in fixed read-wait mode 11.
// RULE21 - read-wait mode: 00 zero, 01 zero-or-one (reset), 10 bad, 11 fixed.
// RULE22 - software discards first status read after an algorithm command.
// RULE23 - sequencer status inputs are same-clock; edges found against a copy.
module fsr_regs
  import fsr_pkg::*;
(
  // clock, reset and enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // flash sequencer status
  input wire logic seq_ready_in,
  input wire logic seq_stall_in,
  input wire logic seq_array_erase_in,
  input wire logic seq_suspend_in,
  input wire logic seq_sector_erase_in,
  input wire logic seq_program_in,
  output logic seq_cmd_accept_out,
  // flash read port for the trim reload
  output logic fl_rd_req_out,
  output logic [31:0] fl_rd_addr_out,
  input wire logic [15:0] fl_rd_data_in,
  input wire logic fl_rd_valid_in,
  input wire logic fl_blank_in,
  // read timing towards the flash read path
  output logic [1:0] read_wait_mode_out,
  output logic [3:0] rd_wait_cycles_out,
  output logic rd_wait_fixed_out,
  // trim values towards the oscillator
  output logic [9:0] freq_trim_mirror_out,
  output logic [4:0] temp_trim_mirror_out,
  output logic trim_valid_out,
  // interrupt to the processor
  output logic irq_out
);

  // software-visible state
  logic [1:0] read_wait_mode;
  logic [3:0] wait_count_field;
  logic stall_irq_enable;
  logic done_irq_enable;
  logic stall_irq_flag;
  logic done_irq_flag;
  logic [9:0] freq_trim_mirror;
  logic [4:0] temp_trim_mirror;
  logic trim_done;

  // decoded strobes
  logic wr_mode;
  logic wr_cnt;
  logic wr_en;
  logic wr_clr;
  logic stall_flag_clear;
  logic done_flag_clear;

  // read path
  logic [31:0] next_rdata;
  logic [7:0] flash_op_status;
  logic [3:0] next_wait_cycles;

  // write decode
  always_comb
  begin
    wr_mode = 1'b0;
    wr_cnt = 1'b0;
    wr_en = 1'b0;
    wr_clr = 1'b0;
    if (reg_wr_in)
    begin
      if (reg_addr_in == `FSR_OFS_WAIT_MODE)
        wr_mode = 1'b1;
      else if (reg_addr_in == `FSR_OFS_WAIT_CNT)
        wr_cnt = 1'b1;
      else if (reg_addr_in == `FSR_OFS_IRQ_EN)
        wr_en = 1'b1;
      else if (reg_addr_in == `FSR_OFS_IRQ_CLR)
        wr_clr = 1'b1;
    end
  end

  // a zero in either clear bit leaves its flag alone
  assign stall_flag_clear = wr_clr && reg_wdata_in[`FSR_IRQ_STALL]; // RULE10 RULE12
  assign done_flag_clear = wr_clr && reg_wdata_in[`FSR_IRQ_DONE]; // RULE11 RULE12

  // read-wait mode; the prohibited code is refused so the path never sees it
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      read_wait_mode <= `FSR_RST_WAIT_MODE; // RULE21
    else if (ce_in && wr_mode && reg_wdata_in[1:0] != `FSR_MODE_BAD)
      read_wait_mode <= reg_wdata_in[1:0]; // RULE21 RULE13
  end

  // wait count; even codes are refused and the old count kept
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      wait_count_field <= `FSR_RST_WAIT_CNT; // RULE19
    else if (ce_in && wr_cnt && reg_wdata_in[0])
      wait_count_field <= reg_wdata_in[3:0]; // RULE19 RULE13
  end

  // interrupt enables
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stall_irq_enable <= 1'(`FSR_RST_IRQ_EN >> `FSR_IRQ_STALL); // RULE5
      done_irq_enable <= 1'(`FSR_RST_IRQ_EN >> `FSR_IRQ_DONE); // RULE6
    end
    else if (ce_in && wr_en)
    begin
      stall_irq_enable <= reg_wdata_in[`FSR_IRQ_STALL];
      done_irq_enable <= reg_wdata_in[`FSR_IRQ_DONE];
    end
  end

  // stall flag follows rising edges of the stall level
  fsr_edge_flag #(
    .PREV_INIT(1'b0)
  ) u_stall_flag (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .level_in(seq_stall_in),
    .clear_in(stall_flag_clear),
    .flag_out(stall_irq_flag)
  ); // RULE8 RULE23

  // ready copy starts high so an idle sequencer does not fake an edge at reset
  fsr_edge_flag #(
    .PREV_INIT(1'b1)
  ) u_done_flag (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .level_in(seq_ready_in),
    .clear_in(done_flag_clear),
    .flag_out(done_irq_flag)
  ); // RULE9 RULE23

  // trim reload runs after every reset, whatever the boot mode
  fsr_trim_loader u_trim (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .fl_rd_req_out(fl_rd_req_out),
    .fl_rd_addr_out(fl_rd_addr_out),
    .fl_rd_data_in(fl_rd_data_in),
    .fl_rd_valid_in(fl_rd_valid_in),
    .fl_blank_in(fl_blank_in),
    .freq_trim_out(freq_trim_mirror),
    .temp_trim_out(temp_trim_mirror),
    .done_out(trim_done)
  ); // RULE14 RULE15 RULE17

  // live status; the sequencer owns the levels, this block only presents them
  always_comb
  begin
    flash_op_status = 8'h00;
    flash_op_status[`FSR_ST_READY] = seq_ready_in; // RULE4
    flash_op_status[`FSR_ST_STALL] = seq_stall_in; // RULE2
    flash_op_status[`FSR_ST_ARRAY_ERASE] = seq_array_erase_in; // RULE1
    flash_op_status[`FSR_ST_SUSPEND] = seq_suspend_in;
    flash_op_status[`FSR_ST_SECTOR_ERASE] = seq_sector_erase_in;
    flash_op_status[`FSR_ST_PROGRAM] = seq_program_in;
  end

  // new commands are only accepted while the sequencer reports ready
  assign seq_cmd_accept_out = seq_ready_in; // RULE4

  // register images: fields in place, reserved bits held at zero
  logic [31:0] mode_word;
  logic [31:0] status_word;
  logic [31:0] enable_word;
  logic [31:0] flag_word;
  logic [31:0] trim_word;
  logic [31:0] count_word;

  always_comb
  begin
    mode_word = 32'h0000_0000;
    mode_word[1:0] = read_wait_mode; // RULE21
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[7:0] = flash_op_status; // RULE1 RULE2 RULE4
  end

  always_comb
  begin
    enable_word = 32'h0000_0000;
    enable_word[`FSR_IRQ_STALL] = stall_irq_enable;
    enable_word[`FSR_IRQ_DONE] = done_irq_enable;
  end

  always_comb
  begin
    flag_word = 32'h0000_0000;
    flag_word[`FSR_IRQ_STALL] = stall_irq_flag; // RULE8
    flag_word[`FSR_IRQ_DONE] = done_irq_flag; // RULE9
  end

  // no boot-mode input gates the mirror, so it reads the same in every mode
  always_comb
  begin
    trim_word = 32'h0000_0000;
    trim_word[`FSR_TRIM_FREQ_MSB:`FSR_TRIM_FREQ_LSB] = freq_trim_mirror; // RULE16
    trim_word[`FSR_TRIM_TEMP_MSB:`FSR_TRIM_TEMP_LSB] = temp_trim_mirror; // RULE16
  end

  always_comb
  begin
    count_word = 32'h0000_0000;
    count_word[3:0] = wait_count_field; // RULE19
  end

  // read mux; reserved and unmapped bits read as zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (reg_addr_in == `FSR_OFS_WAIT_MODE)
      next_rdata = mode_word;
    else if (reg_addr_in == `FSR_OFS_STATUS)
      next_rdata = status_word;
    else if (reg_addr_in == `FSR_OFS_IRQ_EN)
      next_rdata = enable_word;
    else if (reg_addr_in == `FSR_OFS_IRQ_FLAGS)
      next_rdata = flag_word;
    else if (reg_addr_in == `FSR_OFS_IRQ_CLR)
      next_rdata = 32'h0000_0000; // RULE12
    else if (reg_addr_in == `FSR_OFS_TRIM)
      next_rdata = trim_word;
    else if (reg_addr_in == `FSR_OFS_WAIT_CNT)
      next_rdata = count_word;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (ce_in)
      reg_rdata_out <= reg_rd_in ? next_rdata : 32'h0000_0000;
  end

  // programmable count only counts in fixed mode
  always_comb
  begin
    next_wait_cycles = 4'h0;
    if (read_wait_mode == `FSR_MODE_FIXED)
      next_wait_cycles = wait_count_field; // RULE20
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rd_wait_cycles_out <= 4'h0;
      rd_wait_fixed_out <= 1'b0;
      read_wait_mode_out <= `FSR_RST_WAIT_MODE;
    end
    else if (ce_in)
    begin
      rd_wait_cycles_out <= next_wait_cycles; // RULE20
      rd_wait_fixed_out <= (read_wait_mode == `FSR_MODE_FIXED); // RULE20
      read_wait_mode_out <= read_wait_mode; // RULE21
    end
  end

  // trim values towards the oscillator
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      freq_trim_mirror_out <= 10'h000;
      temp_trim_mirror_out <= 5'h00;
    end
    else if (ce_in)
    begin
      freq_trim_mirror_out <= freq_trim_mirror; // RULE15
      temp_trim_mirror_out <= temp_trim_mirror; // RULE14
    end
  end

  // valid moves on the same edge as the copies, so no half load is ever seen
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      trim_valid_out <= 1'b0;
    else if (ce_in)
      trim_valid_out <= trim_done;
  end

  // each source asks only while its own enable allows it
  logic stall_irq_pend;
  logic done_irq_pend;
  assign stall_irq_pend = stall_irq_flag && stall_irq_enable; // RULE5
  assign done_irq_pend = done_irq_flag && done_irq_enable; // RULE6

  // one combined request; a flag left stale by software fires on enable
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      irq_out <= 1'b0;
    else if (ce_in)
      irq_out <= stall_irq_pend || done_irq_pend; // RULE5 RULE6
  end

endmodule

/* File: testbench/fsr_regs_properties.sv */
// port checker for the flash status register set
// bound into fsr_regs; one clock domain, asynchronous active-low reset
`timescale 1ns/100ps
`include "fsr_defs.svh"
module fsr_regs_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // sequencer
  input wire logic seq_ready_in,
  input wire logic seq_stall_in,
  input wire logic seq_array_erase_in,
  input wire logic seq_cmd_accept_out,
  // trim reload
  input wire logic fl_rd_req_out,
  input wire logic [31:0] fl_rd_addr_out,
  input wire logic [15:0] fl_rd_data_in,
  input wire logic fl_rd_valid_in,
  input wire logic [9:0] freq_trim_mirror_out,
  input wire logic [4:0] temp_trim_mirror_out,
  // timing and interrupt
  input wire logic [1:0] read_wait_mode_out,
  input wire logic [3:0] rd_wait_cycles_out,
  input wire logic rd_wait_fixed_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic rd_stat;
  logic take_word;
  logic [15:0] data_q;
  assign rd_stat = ce_in && reg_rd_in && reg_addr_in == `FSR_OFS_STATUS;
  assign take_word = ce_in && fl_rd_req_out && fl_rd_valid_in;
  // the model scrambles its data outside a valid cycle, so keep the taken word
  always_ff @(posedge clk_in)
    if (take_word)
      data_q <= fl_rd_data_in;

  cmd_accept_a: assert property (seq_cmd_accept_out == seq_ready_in)
    else $error("command accept differs from ready");
  stall_bit_a: assert property (
    rd_stat && $stable(seq_stall_in) |=> reg_rdata_out[1] == $past(seq_stall_in))
    else $error("stall status read wrong");
  erase_bit_a: assert property (
    rd_stat && $stable(seq_array_erase_in) |=> reg_rdata_out[2] == $past(seq_array_erase_in))
    else $error("array erase status read wrong");
  irq_off_a: assert property (
    ce_in && reg_wr_in && reg_addr_in == `FSR_OFS_IRQ_EN && reg_wdata_in[1:0] == 2'h0
    |=> ##1 !irq_out) else $error("interrupt stays with enables off");
  clear_reads_a: assert property (
    ce_in && reg_rd_in && reg_addr_in == `FSR_OFS_IRQ_CLR |=> reg_rdata_out == 32'h0)
    else $error("clear register read not zero");
  mode_legal_a: assert property (read_wait_mode_out != 2'h2)
    else $error("prohibited wait mode taken");
  fixed_mode_a: assert property (
    $stable(read_wait_mode_out) |-> rd_wait_fixed_out == (read_wait_mode_out == 2'h3))
    else $error("fixed wait flag disagrees with mode");
  wait_zero_a: assert property (!rd_wait_fixed_out |-> rd_wait_cycles_out == 4'h0)
    else $error("wait count applied outside fixed mode");
  wait_odd_a: assert property (rd_wait_fixed_out |-> rd_wait_cycles_out[0])
    else $error("even wait count in use");
  freq_load_a: assert property (
    take_word && fl_rd_addr_out == `FSR_FL_FREQ_ADDR
    |=> ##1 freq_trim_mirror_out == data_q[9:0])
    else $error("frequency trim not loaded");
  temp_load_a: assert property (
    take_word && fl_rd_addr_out == `FSR_FL_TEMP_ADDR
    |=> ##1 temp_trim_mirror_out == data_q[4:0])
    else $error("temperature trim not loaded");
endmodule

bind fsr_regs fsr_regs_checker u_fsr_regs_checker (.clk_in, .nrst_in, .ce_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .seq_ready_in, .seq_stall_in,
  .seq_array_erase_in, .seq_cmd_accept_out, .fl_rd_req_out, .fl_rd_addr_out, .fl_rd_data_in,
  .fl_rd_valid_in, .freq_trim_mirror_out, .temp_trim_mirror_out, .read_wait_mode_out,
  .rd_wait_cycles_out, .rd_wait_fixed_out, .irq_out);

/* File: testbench/fsr_flash_model.sv */
// flash array stand-in answering the trim reload reads
// answers after delay_in idle cycles of a held request, on the same clock
`timescale 1ns/100ps
`include "fsr_defs.svh"
module fsr_flash_model #(
  parameter logic [15:0] FREQ_WORD = 16'hfa5c,
  parameter logic [15:0] TEMP_WORD = 16'h5ab3
) (
  // clock and pacing
  input wire logic clk_in,
  input wire logic [3:0] delay_in,
  // read port
  input wire logic rd_req_in,
  input wire logic [31:0] rd_addr_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out
);
  logic [3:0] wait_cnt;
  initial
  begin
    rd_valid_out = 1'b0;
    rd_data_out = 16'h0;
    wait_cnt = 4'h0;
  end
  // data toggles outside a valid cycle so a stale sample cannot pass
  always @(posedge clk_in)
  begin
    rd_valid_out <= 1'b0;
    rd_data_out <= ~rd_data_out;
    if (!rd_req_in || rd_valid_out)
      wait_cnt <= 4'h0;
    else if (wait_cnt < delay_in)
      wait_cnt <= wait_cnt + 4'h1;
    else
    begin
      rd_valid_out <= 1'b1;
      rd_data_out <= (rd_addr_in == `FSR_FL_TEMP_ADDR) ? TEMP_WORD : FREQ_WORD;
    end
  end
endmodule

/* File: testbench/fsr_regs_tb.sv */
// self-checking bench for the flash status register set
// drives register port and sequencer levels; a flash model answers trim reads
`timescale 1ns/100ps
module fsr_regs_tb;
  logic clk_in = 1'b0;
  logic nrst_in, ce_in, reg_wr_in, reg_rd_in, fl_rd_valid_in, fl_blank_in, irq_out;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, fl_rd_addr_out;
  logic [15:0] fl_rd_data_in;
  logic seq_ready_in, seq_stall_in, seq_array_erase_in, seq_suspend_in, seq_sector_erase_in;
  logic seq_program_in, seq_cmd_accept_out, fl_rd_req_out, rd_wait_fixed_out, trim_valid_out;
  logic [1:0] read_wait_mode_out;
  logic [3:0] rd_wait_cycles_out, fl_delay;
  logic [9:0] freq_trim_mirror_out;
  logic [4:0] temp_trim_mirror_out;
  logic [5:0] seq_steps [4] = '{6'h00, 6'h3e, 6'h05, 6'h01};
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [31:0] TRIM = 32'h0013_025c;

  fsr_regs u_fsr_regs (.clk_in, .nrst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .seq_ready_in, .seq_stall_in, .seq_array_erase_in,
    .seq_suspend_in, .seq_sector_erase_in, .seq_program_in, .seq_cmd_accept_out,
    .fl_rd_req_out, .fl_rd_addr_out, .fl_rd_data_in, .fl_rd_valid_in, .fl_blank_in,
    .read_wait_mode_out, .rd_wait_cycles_out, .rd_wait_fixed_out, .freq_trim_mirror_out,
    .temp_trim_mirror_out, .trim_valid_out, .irq_out);
  fsr_flash_model u_fsr_flash_model (.clk_in, .delay_in(fl_delay), .rd_req_in(fl_rd_req_out),
    .rd_addr_in(fl_rd_addr_out), .rd_data_out(fl_rd_data_in), .rd_valid_out(fl_rd_valid_in));

  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 check(reg_rdata_out, exp);
  endtask

  // levels change just after an edge, as the sequencer's own flops would
  task automatic set_seq(input logic [5:0] v);
    @(posedge clk_in);
    {seq_program_in, seq_sector_erase_in, seq_suspend_in} <= v[5:3];
    {seq_array_erase_in, seq_stall_in, seq_ready_in} <= v[2:0];
  endtask

  // interrupt output is registered behind flag and enable
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk_in);
    #1 check(irq_out, exp);
  endtask

  task automatic boot(input logic blank, input logic [3:0] dly, input logic [31:0] exp);
    int n;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    fl_blank_in <= blank;
    fl_delay <= dly;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    n = 0;
    while (trim_valid_out !== 1'b1 && n < 40)
    begin
      @(posedge clk_in);
      n++;
    end
    rd(8'h14, exp);
  endtask

  initial
  begin
    {nrst_in, reg_wr_in, reg_rd_in, fl_blank_in} = 4'h0;
    ce_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    fl_delay = 4'h4;
    {seq_program_in, seq_sector_erase_in, seq_suspend_in} = 3'h0;
    {seq_array_erase_in, seq_stall_in, seq_ready_in} = 3'h1;
    boot(1'b0, 4'h4, TRIM);
    rd(8'h00, 32'h1);
    rd(8'h18, 32'h1);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h0);
    $display("test reset values done");
    foreach (seq_steps[i])
    begin
      set_seq(seq_steps[i]);
      rd(8'h04, {26'h0, seq_steps[i]});
      rd(8'h04, {26'h0, seq_steps[i]});
      check(seq_cmd_accept_out, seq_steps[i][0]);
    end
    rd(8'h0c, 32'h3);
    wr(8'h10, 32'h0);
    rd(8'h0c, 32'h3);
    irq_is(1'b0);
    wr(8'h10, 32'h1);
    rd(8'h0c, 32'h2);
    wr(8'h08, 32'h1);
    irq_is(1'b0);
    wr(8'h10, 32'h2);
    rd(8'h0c, 32'h0);
    wr(8'h08, 32'h3);
    irq_is(1'b0);
    set_seq(6'h03);
    irq_is(1'b1);
    wr(8'h10, 32'h2);
    irq_is(1'b0);
    set_seq(6'h01);
    set_seq(6'h00);
    set_seq(6'h01);
    irq_is(1'b1);
    set_seq(6'h03);
    wr(8'h08, 32'h0);
    irq_is(1'b0);
    rd(8'h0c, 32'h3);
    $display("test flags and interrupt done");
    wr(8'h00, 32'h2);
    rd(8'h00, 32'h1);
    wr(8'h00, 32'h3);
    for (int c = 1; c < 16; c += 2)
    begin
      wr(8'h18, 32'(c));
      @(posedge clk_in);
      #1 check(rd_wait_cycles_out, 32'(c));
    end
    check(rd_wait_fixed_out, 32'h1);
    wr(8'h18, 32'h4);
    rd(8'h18, 32'hf);
    wr(8'h18, 32'hffff_fff5);
    rd(8'h18, 32'h5);
    wr(8'h00, 32'h0);
    @(posedge clk_in);
    #1 check(rd_wait_cycles_out, 32'h0);
    rd(8'h00, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
    $display("test read wait done");
    rd(8'h14, TRIM);
    boot(1'b1, 4'h0, 32'h0);
    boot(1'b0, 4'h0, TRIM);
    $display("test trim reload done");
    stop_test();
  end
endmodule
